// ===== verilog/tx_output_consts.vh
// Constants for the transmit output and status multiplexer block.
// Function
// - Six-bit field sets amplifier output level
// - Power-enable low powers down output stage
// - Keyed mode ramps level in filtered steps
// - Sample clock is phase-detector rate over divider times index
// - Six-bit keyed-on level, 0x3f full swing
// - Device drives sample clock; host syncs data
// - Host changes on fall; device samples rise
// - Divider code: bypass, two, four, eight
// - Output divider sits inside feedback loop
// - Four-bit select routes signal to status pin
// - Codes 1010-1101 show supply threshold compares
// - Status select defaults to regulator ready
// - Lock after 3 or 5 good cycles
// - Status pin shows reference pulse or half
// - Phase-detector rate is reference divided
`ifndef TX_OUTPUT_CONSTS_VH
`define TX_OUTPUT_CONSTS_VH

// ****************************************************************
// Status pin selection codes.
// ****************************************************************
`define SEL_LOW 4'h0
`define SEL_REG_READY 4'h1
`define SEL_LOCK 4'h2
`define SEL_REF_PULSE 4'h3
`define SEL_REF_HALF 4'h4
`define SEL_HIGH 4'h5
`define SEL_SUP_325 4'ha
`define SEL_SUP_300 4'hb
`define SEL_SUP_275 4'hc
`define SEL_SUP_235 4'hd

// ****************************************************************
// Output divider codes and field widths.
// ****************************************************************
`define DIV_OFF 2'h0
`define DIV_2 2'h1
`define DIV_4 2'h2
`define DIV_8 2'h3
`define LOCK_CNT_LO 3'h3
`define LOCK_CNT_HI 3'h5
`define LEVEL_W 6
`define LEVEL_OFF 6'h00
`define FIFO_DEPTH 16

`endif

// ===== verilog/bit_fifo.v
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module bit_fifo
#(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire clock_i,
    input wire rst_b_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    // Storage array.
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // Read and write pointers, one extra bit to tell full from empty.
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;
    wire push;
    wire pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                  (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    assign push = in_valid_i && ~full;
    assign pop = out_ready_i && ~empty;

    // Write the array on an accepted push.
    always @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // Pointer advance.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // bit_fifo

// ===== verilog/tx_output_and_status_mux.v
// Amplifier level control, keyed ramping, sample clock and status pin.
`timescale 1ns/1ps
`include "tx_output_consts.vh"
module tx_output_and_status_mux
#(
    parameter REF_DIV_W = 8,
    parameter DIVF_W = 7
)
(
    input wire clock_i,
    input wire rst_b_i,
    input wire [REF_DIV_W-1:0] ref_div_i,
    input wire [5:0] pa_level_field_i,
    input wire pa_power_enable_i,
    input wire keyed_mode_i,
    input wire [5:0] keyed_on_level_i,
    input wire [DIVF_W-1:0] divider_factor_i,
    input wire [1:0] index_sel_i,
    input wire out_div_sel_hi_i,
    input wire out_div_sel_lo_i,
    input wire vco_i,
    input wire [3:0] status_select_field_i,
    input wire status_select_load_i,
    input wire regulator_ready_i,
    input wire phase_good_i,
    input wire lock_precision_bit_i,
    input wire [3:0] digital_supply_above_i,
    input wire tx_bit_in_i,
    output reg [5:0] pa_level_o,
    output reg pa_enable_o,
    output reg tx_sample_clock_o,
    output reg divided_out_o,
    output reg status_pin_o,
    output reg lock_detect_o,
    output reg bit_overflow_o
);
    // ****************************************************************
    // Input synchronisers for pin inputs.
    // ****************************************************************
    // Three-stage chains; a change counts when stages two and three agree.
    reg [2:0] tx_sync;
    reg [2:0] vco_sync;
    reg [2:0] phase_sync;
    reg [2:0] reg_sync;
    // Filtered copies of the synchronised levels.
    reg tx_clean;
    reg vco_clean;
    reg phase_clean;
    reg reg_clean;

    // Shift the chains and update the clean level on agreement.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_sync <= 3'h0;
            vco_sync <= 3'h0;
            phase_sync <= 3'h0;
            reg_sync <= 3'h0;
            tx_clean <= 1'b0;
            vco_clean <= 1'b0;
            phase_clean <= 1'b0;
            reg_clean <= 1'b0;
        end
        else
        begin
            tx_sync <= {tx_sync[1:0], tx_bit_in_i};
            vco_sync <= {vco_sync[1:0], vco_i};
            phase_sync <= {phase_sync[1:0], phase_good_i};
            reg_sync <= {reg_sync[1:0], regulator_ready_i};
            if (tx_sync[1] == tx_sync[2])
            begin
                tx_clean <= tx_sync[2];
            end
            if (vco_sync[1] == vco_sync[2])
            begin
                vco_clean <= vco_sync[2];
            end
            if (phase_sync[1] == phase_sync[2])
            begin
                phase_clean <= phase_sync[2];
            end
            if (reg_sync[1] == reg_sync[2])
            begin
                reg_clean <= reg_sync[2];
            end
        end
    end

    // ****************************************************************
    // Reference divider producing the phase-detector enable.
    // ****************************************************************
    // A zero divide setting passes the reference straight through.
    reg [REF_DIV_W-1:0] ref_cnt;
    reg pfd_tick;
    reg pfd_half;

    // Count down and pulse one cycle per phase-detector period.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ref_cnt <= {REF_DIV_W{1'b0}};
            pfd_tick <= 1'b0;
            pfd_half <= 1'b0;
        end
        else if (ref_cnt == {REF_DIV_W{1'b0}})
        begin
            ref_cnt <= ref_div_i;
            pfd_tick <= 1'b1;
            pfd_half <= ~pfd_half;
        end
        else
        begin
            ref_cnt <= ref_cnt - 1'b1;
            pfd_tick <= 1'b0;
        end
    end

    // ****************************************************************
    // Sample clock: phase-detector rate over divider times index.
    // ****************************************************************
    // Index count per code: 16, 32, 64, 128 steps per transition.
    wire [7:0] index_steps;
    assign index_steps = 8'h10 << index_sel_i;
    reg [DIVF_W-1:0] divf_cnt;
    reg [7:0] step_cnt;
    reg step_tick;
    wire divf_done;
    // A zero divider factor behaves as a factor of one.
    assign divf_done = (divider_factor_i == {DIVF_W{1'b0}}) ||
                       (divf_cnt >= divider_factor_i - 1'b1);

    // Divider factor prescaler makes the per-step tick.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            divf_cnt <= {DIVF_W{1'b0}};
            step_cnt <= 8'h00;
            step_tick <= 1'b0;
            tx_sample_clock_o <= 1'b0;
        end
        else if (!keyed_mode_i)
        begin
            divf_cnt <= {DIVF_W{1'b0}};
            step_cnt <= 8'h00;
            step_tick <= 1'b0;
            tx_sample_clock_o <= 1'b0;
        end
        else if (pfd_tick)
        begin
            step_tick <= divf_done;
            divf_cnt <= divf_done ? {DIVF_W{1'b0}} :
                divf_cnt + 1'b1;
            if (divf_done)
            begin
                // Step counter spans one symbol; clock high in 2nd half.
                step_cnt <= (step_cnt >= index_steps - 8'h01) ? 8'h00 :
                    step_cnt + 8'h01;
                tx_sample_clock_o <= (step_cnt >= (index_steps >> 1) - 8'h01)
                    && (step_cnt != index_steps - 8'h01);
            end
        end
        else
        begin
            step_tick <= 1'b0;
        end
    end

    // Rising edge of the driven sample clock marks mid-bit.
    reg sample_clk_d;
    wire sample_rise;
    assign sample_rise = tx_sample_clock_o && !sample_clk_d;

    // ****************************************************************
    // Sampled data buffer.
    // ****************************************************************
    wire fifo_in_ready;
    wire fifo_out_data;
    wire fifo_out_valid;
    reg symbol_start;

    bit_fifo #(
        .WIDTH(1),
        .DEPTH(`FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .in_data_i(tx_clean),
        .in_valid_i(sample_rise),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(symbol_start)
    );

    // Edge tracking, symbol pacing and overflow flag.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sample_clk_d <= 1'b0;
            symbol_start <= 1'b0;
            bit_overflow_o <= 1'b0;
        end
        else
        begin
            sample_clk_d <= tx_sample_clock_o;
            // The ramp pulls one bit per symbol boundary.
            symbol_start <= step_tick && (step_cnt == 8'h00);
            if (sample_rise && !fifo_in_ready)
            begin
                bit_overflow_o <= 1'b1;
            end
            else if (!keyed_mode_i)
            begin
                bit_overflow_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Gaussian ramp of the amplifier level.
    // ****************************************************************
    // Current bit, ramp position (0..255 scaled) and target.
    reg cur_bit;
    reg [7:0] ramp_pos;
    wire [7:0] ramp_inc;
    // Step size makes a full ramp in one symbol of index_steps steps.
    assign ramp_inc = 8'h80 >> (3'h3 + {1'b0, index_sel_i});
    // Smoothstep shaping approximates the filtered edge.
    wire [15:0] pos_sq;
    wire [23:0] shaped_full;
    wire [7:0] shaped;
    assign pos_sq = ramp_pos * ramp_pos;
    assign shaped_full = pos_sq * (16'h0300 - {7'h00, ramp_pos, 1'b0});
    assign shaped = shaped_full[23:16];
    wire [13:0] lvl_prod;
    assign lvl_prod = shaped * keyed_on_level_i;

    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_bit <= 1'b0;
            ramp_pos <= 8'h00;
        end
        else if (!keyed_mode_i)
        begin
            cur_bit <= 1'b0;
            ramp_pos <= 8'h00;
        end
        else
        begin
            if (symbol_start && fifo_out_valid)
            begin
                cur_bit <= fifo_out_data;
            end
            if (step_tick)
            begin
                // Move one discrete step toward the target level.
                if (cur_bit && ramp_pos <= 8'hff - ramp_inc)
                begin
                    ramp_pos <= ramp_pos + ramp_inc;
                end
                else if (cur_bit)
                begin
                    ramp_pos <= 8'hff;
                end
                else if (ramp_pos >= ramp_inc)
                begin
                    ramp_pos <= ramp_pos - ramp_inc;
                end
                else
                begin
                    ramp_pos <= 8'h00;
                end
            end
        end
    end

    // Amplifier outputs.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pa_level_o <= `LEVEL_OFF;
            pa_enable_o <= 1'b0;
        end
        else
        begin
            pa_enable_o <= pa_power_enable_i;
            if (!pa_power_enable_i)
            begin
                pa_level_o <= `LEVEL_OFF;
            end
            else if (keyed_mode_i)
            begin
                pa_level_o <= lvl_prod[13:8];
            end
            else
            begin
                pa_level_o <= pa_level_field_i;
            end
        end
    end

    // ****************************************************************
    // Output divider inside the feedback path.
    // ****************************************************************
    // Feeds both the amplifier and the feedback divider, so N is unchanged.
    reg [2:0] od_cnt;
    reg vco_d;
    wire [1:0] od_sel;
    assign od_sel = {out_div_sel_hi_i, out_div_sel_lo_i};

    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            od_cnt <= 3'h0;
            vco_d <= 1'b0;
            divided_out_o <= 1'b0;
        end
        else
        begin
            vco_d <= vco_clean;
            if (vco_clean && !vco_d)
            begin
                od_cnt <= od_cnt + 3'h1;
            end
            case (od_sel)
                `DIV_OFF: divided_out_o <= vco_clean;
                `DIV_2: divided_out_o <= od_cnt[0];
                `DIV_4: divided_out_o <= od_cnt[1];
                `DIV_8: divided_out_o <= od_cnt[2];
                default: divided_out_o <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Digital lock detect.
    // ****************************************************************
    reg [2:0] good_cnt;
    wire [2:0] lock_need;
    assign lock_need = lock_precision_bit_i ? `LOCK_CNT_HI : `LOCK_CNT_LO;

    // Count consecutive good phase-detector cycles.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            good_cnt <= 3'h0;
            lock_detect_o <= 1'b0;
        end
        else if (pfd_tick)
        begin
            if (!phase_clean)
            begin
                good_cnt <= 3'h0;
                lock_detect_o <= 1'b0;
            end
            else
            begin
                if (good_cnt < lock_need)
                begin
                    good_cnt <= good_cnt + 3'h1;
                end
                lock_detect_o <= (good_cnt + 3'h1 >= lock_need);
            end
        end
    end

    // ****************************************************************
    // Status pin multiplexer.
    // ****************************************************************
    reg [3:0] sel;

    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel <= `SEL_REG_READY;
            status_pin_o <= 1'b0;
        end
        else
        begin
            if (status_select_load_i)
            begin
                sel <= status_select_field_i;
            end
            case (sel)
                `SEL_LOW: status_pin_o <= 1'b0;
                `SEL_REG_READY: status_pin_o <= reg_clean;
                `SEL_LOCK: status_pin_o <= lock_detect_o;
                `SEL_REF_PULSE: status_pin_o <= pfd_tick;
                `SEL_REF_HALF: status_pin_o <= pfd_half;
                `SEL_HIGH: status_pin_o <= 1'b1;
                `SEL_SUP_325: status_pin_o <= digital_supply_above_i[0];
                `SEL_SUP_300: status_pin_o <= digital_supply_above_i[1];
                `SEL_SUP_275: status_pin_o <= digital_supply_above_i[2];
                `SEL_SUP_235: status_pin_o <= digital_supply_above_i[3];
                default: status_pin_o <= 1'b0;
            endcase
        end
    end
endmodule // tx_output_and_status_mux

// ===== dv/tx_output_and_status_mux_checker.sv
// Port-level assertions for the transmit output and status mux.
`timescale 1ns/1ps
`include "tx_output_consts.vh"
module tx_output_and_status_mux_checker
#(
    parameter REF_DIV_W = 8
)
(
    input wire clock_i,
    input wire rst_b_i,
    input wire [REF_DIV_W-1:0] ref_div_i,
    input wire [5:0] pa_level_field_i,
    input wire pa_power_enable_i,
    input wire keyed_mode_i,
    input wire [5:0] keyed_on_level_i,
    input wire [3:0] status_select_field_i,
    input wire status_select_load_i,
    input wire regulator_ready_i,
    input wire phase_good_i,
    input wire lock_precision_bit_i,
    input wire [3:0] digital_supply_above_i,
    input wire [5:0] pa_level_o,
    input wire status_pin_o,
    input wire lock_detect_o,
    input wire bit_overflow_o
);
    // ****************************************
    // Helper state mirrored from the inputs.
    // ****************************************
    reg [3:0] sel_c; // Copy of the loaded status selection.
    reg [11:0] good_cnt; // Cycles in a row with phase good.
    reg [11:0] bad_cnt; // Cycles in a row with phase bad.
    wire [11:0] per = ref_div_i + 12'h001; // Clocks per phase tick.
    wire [11:0] need = lock_precision_bit_i ? 12'h005 : 12'h003;
    wire fixed_sel = sel_c == 4'h0 || sel_c >= 4'he
        || (sel_c >= 4'h5 && sel_c <= 4'h9);
    wire sup_sel = sel_c >= 4'ha && sel_c <= 4'hd;
    wire sup_val = digital_supply_above_i[sel_c[1:0] - 2'h2];
    // Track the selection and the run lengths of phase samples.
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel_c <= `SEL_REG_READY;
            good_cnt <= 12'h000;
            bad_cnt <= 12'h000;
        end
        else
        begin
            if (status_select_load_i)
                sel_c <= status_select_field_i;
            good_cnt <= phase_good_i ? good_cnt + 12'h001 : 12'h000;
            bad_cnt <= phase_good_i ? 12'h000 : bad_cnt + 12'h001;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // ****************************************
    // Assertions.
    // ****************************************
    a_power_off_zero: assert property (
        $past(!pa_power_enable_i) |-> pa_level_o == `LEVEL_OFF)
        else $error("level not zero while powered down");
    a_static_level: assert property (
        $past(rst_b_i && pa_power_enable_i && !keyed_mode_i)
        |-> pa_level_o == $past(pa_level_field_i))
        else $error("static level not applied");
    a_status_fixed: assert property (
        $past(rst_b_i && fixed_sel)
        |-> status_pin_o == $past(sel_c == `SEL_HIGH))
        else $error("fixed status code wrong");
    a_status_supply: assert property (
        $past(rst_b_i && sup_sel) |-> status_pin_o == $past(sup_val))
        else $error("supply compare not on status pin");
    a_ready_default: assert property (
        (sel_c == `SEL_REG_READY && $stable(regulator_ready_i))[*6]
        |-> status_pin_o == regulator_ready_i)
        else $error("regulator ready not shown");
    a_lock_drop_bad: assert property (
        bad_cnt == per + 12'h006 |-> !lock_detect_o)
        else $error("lock held through bad phase");
    a_lock_too_early: assert property (
        $rose(lock_detect_o) |-> good_cnt >= (need - 12'h001) * per)
        else $error("lock before enough good cycles");
    a_lock_too_late: assert property (
        good_cnt == need * per + 12'h008 |-> lock_detect_o)
        else $error("lock missing after good cycles");
    a_keyed_level_cap: assert property (
        keyed_mode_i[*2] |-> pa_level_o <= keyed_on_level_i)
        else $error("keyed level above on level");
    a_overflow_clear: assert property (
        (!keyed_mode_i)[*2] |-> !bit_overflow_o)
        else $error("overflow flag outside keyed mode");
    c_lock_up: cover property ($rose(lock_detect_o));
    c_supply_high: cover property (sup_sel && status_pin_o);
    c_keyed_up: cover property (keyed_mode_i && pa_level_o > 6'h20);
endmodule // tx_output_and_status_mux_checker

bind tx_output_and_status_mux tx_output_and_status_mux_checker
    #(.REF_DIV_W(REF_DIV_W)) chk_u (.*);

// ===== dv/tx_host_model.sv
// Host side model: feeds transmit bits in step with the sample clock.
`timescale 1ns/1ps
module tx_host_model
(
    input wire tx_sample_clock_i,
    input wire [7:0] lag_i,
    output reg tx_bit_o
);
    bit q[$]; // Bits waiting to go out, oldest first.
    initial tx_bit_o = 1'b0;
    // Change data after the falling edge, so it is steady at the rise.
    always @(negedge tx_sample_clock_i)
    begin
        #(lag_i);
        tx_bit_o = (q.size() > 0) ? q.pop_front() : 1'b0;
    end
    // Queue one bit for a later symbol.
    task push(input bit b);
        q.push_back(b);
    endtask
endmodule // tx_host_model

// ===== dv/tx_output_and_status_mux_tb.sv
// Self-checking bench for the transmit output and status mux.
`timescale 1ns/1ps
`include "tx_output_consts.vh"
module tx_output_and_status_mux_tb;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] ref_div_i = 8'h03;
    logic [5:0] pa_level_field_i = 6'h00;
    logic pa_power_enable_i = 1'b1;
    logic keyed_mode_i = 1'b0;
    logic [5:0] keyed_on_level_i = 6'h3f;
    logic [6:0] divider_factor_i = 7'h01;
    logic [1:0] index_sel_i = 2'h0;
    logic out_div_sel_hi_i = 1'b0;
    logic out_div_sel_lo_i = 1'b0;
    logic vco_i = 1'b0;
    logic [2:0] vco_cnt = 3'h0; // Slow oscillator stand-in divider.
    logic [3:0] status_select_field_i = 4'h0;
    logic status_select_load_i = 1'b0;
    logic regulator_ready_i = 1'b0;
    logic phase_good_i = 1'b0;
    logic lock_precision_bit_i = 1'b0;
    logic [3:0] digital_supply_above_i = 4'h0;
    wire tx_bit_in_i;
    wire [5:0] pa_level_o;
    wire pa_enable_o;
    wire tx_sample_clock_o;
    wire divided_out_o;
    wire status_pin_o;
    wire lock_detect_o;
    wire bit_overflow_o;
    int bad_count = 0;
    int num_checks = 0;
    int seed = 42644;
    int i, n, e, v, pk, dm, d;
    logic p;
    tx_output_and_status_mux dut_u (.*);
    tx_host_model host_u (.tx_sample_clock_i(tx_sample_clock_o),
        .lag_i(8'hfa), .tx_bit_o(tx_bit_in_i));
    initial forever #50 clock_i = ~clock_i;
    // Oscillator stand-in with a period of eight clocks.
    always @(posedge clock_i)
    begin
        vco_cnt <= vco_cnt + 3'h1;
        vco_i <= vco_cnt[2];
    end
    // Compare one value with its expectation.
    task check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wait_c(input int c);
        repeat (c) @(posedge clock_i);
    endtask
    // Pulse a new status selection in and let it reach the pin.
    task sel_load(input logic [3:0] c);
        status_select_field_i <= c;
        status_select_load_i <= 1'b1;
        wait_c(1);
        status_select_load_i <= 1'b0;
        wait_c(4);
    endtask
    // Count clocks up to the next rise of the sample clock.
    task rise(output int c);
        c = 0;
        do
        begin
            p = tx_sample_clock_o;
            wait_c(1);
            c++;
        end
        while (!(p === 1'b0 && tx_sample_clock_o === 1'b1) && c < 999);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run length.
    initial
    begin
        #2000000;
        bad_count++;
        finish_test();
    end
    initial
    begin
        wait_c(16);
        check({pa_level_o, pa_enable_o, tx_sample_clock_o, divided_out_o,
            status_pin_o, lock_detect_o, bit_overflow_o}, 12'h000);
        rst_b_i <= 1'b1;
        wait_c(8);
        check(status_pin_o, 1'b0);
        regulator_ready_i <= 1'b1;
        wait_c(8);
        check(status_pin_o, 1'b1);
        $display("reset test done");
        for (i = 0; i < 10; i++)
        begin
            v = (i == 0) ? 0 : (i == 1) ? 63 : $random(seed);
            pa_level_field_i <= v[5:0];
            wait_c(3);
            check(pa_level_o, v[5:0]);
            check(pa_enable_o, 1'b1);
        end
        pa_power_enable_i <= 1'b0;
        wait_c(3);
        check({pa_enable_o, pa_level_o}, 7'h00);
        pa_power_enable_i <= 1'b1;
        $display("level test done");
        for (i = 0; i < 16; i++)
        begin
            v = $random(seed);
            digital_supply_above_i <= v[3:0];
            if (i < 2 || i > 4)
            begin
                sel_load(i[3:0]);
                if (i >= 10 && i <= 13)
                    check(status_pin_o, v[i - 10]);
                else if (i != 1)
                    check(status_pin_o, i == 5);
            end
        end
        for (i = 3; i < 5; i++)
        begin
            sel_load(i[3:0]);
            n = 0;
            repeat (40)
            begin
                wait_c(1);
                n += (status_pin_o === 1'b1);
            end
            check(n, (i == 3) ? 10 : 20);
        end
        $display("status test done");
        sel_load(`SEL_LOCK);
        for (i = 0; i < 2; i++)
        begin
            lock_precision_bit_i <= i[0];
            phase_good_i <= 1'b0;
            wait_c(20);
            check(status_pin_o, 1'b0);
            phase_good_i <= 1'b1;
            n = 0;
            e = i ? 5 : 3;
            while (lock_detect_o !== 1'b1 && n < 99)
            begin
                wait_c(1);
                n++;
            end
            check(n >= (e - 1) * 4 && n <= e * 4 + 8, 1'b1);
            wait_c(30);
            check(status_pin_o, 1'b1);
        end
        phase_good_i <= 1'b0;
        wait_c(12);
        check(lock_detect_o, 1'b0);
        $display("lock test done");
        for (i = 0; i < 4; i++)
        begin
            {out_div_sel_hi_i, out_div_sel_lo_i} <= i[1:0];
            wait_c(40);
            n = 0;
            repeat (256)
            begin
                p = divided_out_o;
                wait_c(1);
                n += (p === 1'b0 && divided_out_o === 1'b1);
            end
            e = 32 >> i;
            check(n >= e - 1 && n <= e + 1, 1'b1);
        end
        $display("divider test done");
        ref_div_i <= 8'h00;
        keyed_mode_i <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            index_sel_i <= i[1:0];
            rise(n);
            rise(n);
            rise(n);
            check(n, 16 << i);
        end
        // A divider factor of three stretches each step to three ticks.
        divider_factor_i <= 7'h03;
        rise(n);
        rise(n);
        rise(n);
        check(n, 384);
        divider_factor_i <= 7'h01;
        for (i = 0; i < 8; i++)
            host_u.push(i < 4);
        pk = 0;
        dm = 0;
        repeat (1400)
        begin
            v = pa_level_o;
            wait_c(1);
            d = pa_level_o - v;
            dm = (d > dm) ? d : (-d > dm) ? -d : dm;
            pk = (pa_level_o > pk) ? pa_level_o : pk;
        end
        check(pk >= 59 && pk <= 63, 1'b1);
        check(dm <= 4, 1'b1);
        check({bit_overflow_o, pa_level_o}, 7'h00);
        keyed_mode_i <= 1'b0;
        wait_c(3);
        check(bit_overflow_o, 1'b0);
        $display("keyed test done");
        finish_test();
    end
endmodule // tx_output_and_status_mux_tb
